// ===== csc_regs.svh
// register offsets, field positions, reset values and counts of the socket bank
// assumes byte addresses on a 32-bit register bus
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

`define CSC_OFF_EVENT       6'h00
`define CSC_OFF_MASK        6'h04
`define CSC_OFF_PRESENT     6'h08
`define CSC_OFF_FORCE       6'h0c
`define CSC_OFF_POWER       6'h10
`define CSC_OFF_CLOCK       6'h20

`define CSC_RESET_WORD      32'h0000_0000

// empty-socket pin levels: detects and sense pulled high, run line held low by us
`define CSC_SYNC_IDLE       7'h0f
`define CSC_DETECT_IDLE     2'h3

`define CSC_B_PWRCYC        3
`define CSC_B_CD2           2
`define CSC_B_CD1           1
`define CSC_B_STSCHG        0
`define CSC_B_SOCK3V        29
`define CSC_B_SOCK5V        28
`define CSC_B_VSTEST        14
`define CSC_B_CARD3V        11
`define CSC_B_CARD5V        10
`define CSC_B_ILLVCC        9
`define CSC_B_LOST          8
`define CSC_B_UNREC         7
`define CSC_B_CB            5
`define CSC_B_B16           4
`define CSC_B_SDIS          1
`define CSC_B_CSTOP         0

`define CSC_VCC_LSB         4
`define CSC_CODE_OFF        3'h0
`define CSC_CODE_12V        3'h1
`define CSC_CODE_5V         3'h2
`define CSC_CODE_3V         3'h3

`define CSC_STOP_CLOCKS     3'h4

`endif

// ===== csc_pkg.sv
// types of the socket status and control bank
// assumes csc_regs.svh for the numbers
package csc_pkg;

   typedef enum logic [1:0] {
      CSC_CLK_RUN,
      CSC_CLK_STOPPING,
      CSC_CLK_STOPPED
   } csc_clk_state_t;

   typedef struct packed {
      logic [6:0]     sync1;
      logic [6:0]     sync2;
      logic [1:0]     cd_prev;
      logic           sts_prev;
      logic           pwr_prev;
      logic           present_prev;
      logic [3:0]     evt;
      logic [3:0]     msk;
      logic           card3v;
      logic           card5v;
      logic           vs_ok;
      logic           illvcc;
      logic           lost;
      logic           unrec;
      logic           cb;
      logic           b16;
      logic [2:0]     vcc;
      logic [2:0]     vpp;
      logic           sdis;
      logic           cstop;
      logic [7:0]     div;
      logic           card_bus_clock;
      logic [2:0]     stop_cnt;
      csc_clk_state_t clk_st;
      logic           ack;
      logic [31:0]    rdata;
   } csc_state_t;

endpackage

// ===== csc_socket_bank.sv
// socket event, mask, present-state, force, power and card clock registers
// assumes an avalon-mm master on clk_i and card pins from outside this clock
//
// What this block does
// - power cycle enable zero blocks its interrupt
// - detect mask 00 blocks, 11 allows; flags set
// - status pin enable gates; cleared on removal, reset
// - present bits report socket 3.3V and 5V
// - card voltage flags decoded from sense, detect
// - no 5V vcc applied to 32-bit bus card
// - flag software vcc request outside detected range
// - flag data lost on removal mid transfer
// - unrecognized flag held until recognizable card
// - card type flags steer interface, held
// - power cycle bit shows powered interface
// - mirror live detect and status change pins
// - force address stores nothing, writes other registers
// - retest bit resamples pins, refreshes voltage flags
// - forced voltage flag blocks vcc until retest
// - forced flags pass; type flags ignored with card
// - forced event bits set events only, zero ignored
// - vcc codes off, 5V, 3.3V; others reserved
// - vpp codes off, 12V, 5V, 3.3V; rest reserved
// - start disable stops clock unless card runs it
// - clock stop drives run line high, stops after 4
// - reserved bits read zero, all but socket and pin bits reset zero
//
// Our own choice: the Avalon-MM slave port.
`include "csc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module csc_socket_bank
   import csc_pkg::*;
#(
   parameter bit         SOCK_3V   = 1'b1,
   parameter bit         SOCK_5V   = 1'b1,
   parameter int unsigned CARD_BUS_CLOCK_HALF = 4
) (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic [5:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output var  logic [31:0] avs_readdata_o,
   output var  logic        avs_waitrequest_o,
   input  wire logic        card_detect_first_n_i,
   input  wire logic        card_detect_second_n_i,
   input  wire logic [1:0]  card_voltage_sense_i,
   input  wire logic        card_status_change_pin_i,
   input  wire logic        card_clock_run_n_i,
   output var  logic        card_clock_run_n_o,
   output var  logic        card_clock_run_n_oe_o,
   output var  logic        card_bus_clock_o,
   input  wire logic        power_good_i,
   input  wire logic        xfer_pending_i,
   output var  logic [2:0]  vcc_request_o,
   output var  logic [2:0]  vpp_request_o,
   output var  logic        mode_cardbus_o,
   output var  logic        mode_16bit_o,
   output var  logic        status_change_irq_o
);

   initial begin
      if (CARD_BUS_CLOCK_HALF < 1 || CARD_BUS_CLOCK_HALF > 255)
         $error("CARD_BUS_CLOCK_HALF must lie in 1..255");
   end

   localparam logic [7:0] HALF_M1 = 8'(CARD_BUS_CLOCK_HALF - 1);

   // synchronisers and edge memories start at the empty-socket pin levels,
   // so a release of reset shows no phantom insertion, removal or detect event
   localparam csc_state_t ST_RESET = '{
      sync1:   `CSC_SYNC_IDLE,
      sync2:   `CSC_SYNC_IDLE,
      cd_prev: `CSC_DETECT_IDLE,
      clk_st:  CSC_CLK_RUN,
      default: '0
   };

   csc_state_t st_reg;
   csc_state_t st_next;

   // synchronised pins: [0] cd1 [1] cd2 [3:2] sense [4] status [5] clkrun [6] power
   logic       cd1_s, cd2_s, sts_s, clkrun_n_s, pwr_s, present_s;
   logic [1:0] vs_s;
   logic       wr_acc, rd_acc;
   logic [31:0] wmask, wdat;
   logic       vcc_legal, retest, sample;
   logic [31:0] present_word;

   assign cd1_s      = st_reg.sync2[0];
   assign cd2_s      = st_reg.sync2[1];
   assign vs_s       = st_reg.sync2[3:2];
   assign sts_s      = st_reg.sync2[4];
   assign clkrun_n_s = st_reg.sync2[5];
   assign pwr_s      = st_reg.sync2[6];
   assign present_s  = ~cd1_s & ~cd2_s;

   // one wait state: reads sample on the edge that drops waitrequest, writes take effect on the edge after
   assign wr_acc = avs_write_i & ~avs_read_i & st_reg.ack;
   assign rd_acc = avs_read_i & ~avs_write_i;
   assign wmask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   assign wdat   = avs_writedata_i & wmask;
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_reg.ack;
   assign avs_readdata_o    = st_reg.rdata;

   // power may only go on after a real sense of the pins and a legal code
   always_comb begin
      vcc_legal = 1'b0;
      case (st_reg.vcc)
         `CSC_CODE_OFF: vcc_legal = 1'b1;
         `CSC_CODE_5V:  vcc_legal = st_reg.card5v & ~st_reg.cb;
         `CSC_CODE_3V:  vcc_legal = st_reg.card3v;
         default:       vcc_legal = 1'b0;
      endcase
   end

   always_comb begin
      present_word = `CSC_RESET_WORD;
      present_word[`CSC_B_SOCK3V] = SOCK_3V;
      present_word[`CSC_B_SOCK5V] = SOCK_5V;
      present_word[`CSC_B_CARD3V] = st_reg.card3v;
      present_word[`CSC_B_CARD5V] = st_reg.card5v;
      present_word[`CSC_B_ILLVCC] = st_reg.illvcc;
      present_word[`CSC_B_LOST]   = st_reg.lost;
      present_word[`CSC_B_UNREC]  = st_reg.unrec;
      present_word[`CSC_B_CB]     = st_reg.cb;
      present_word[`CSC_B_B16]    = st_reg.b16;
      present_word[`CSC_B_PWRCYC] = pwr_s & (vcc_request_o != `CSC_CODE_OFF);
      present_word[`CSC_B_CD2]    = cd2_s;
      present_word[`CSC_B_CD1]    = cd1_s;
      present_word[`CSC_B_STSCHG] = sts_s;
   end

   assign vcc_request_o = (st_reg.vs_ok & present_s & vcc_legal) ? st_reg.vcc
                                                                  : `CSC_CODE_OFF;
   assign vpp_request_o = (st_reg.vs_ok & present_s & ~st_reg.vpp[2]) ? st_reg.vpp
                                                                       : `CSC_CODE_OFF;
   assign mode_cardbus_o = st_reg.cb;
   assign mode_16bit_o   = st_reg.b16;
   assign status_change_irq_o =
        (st_reg.evt[`CSC_B_PWRCYC] & st_reg.msk[`CSC_B_PWRCYC])
      | (|(st_reg.evt[2:1] & st_reg.msk[2:1]))
      | (st_reg.evt[`CSC_B_STSCHG] & st_reg.msk[`CSC_B_STSCHG]);
   assign card_bus_clock_o     = st_reg.card_bus_clock;
   assign card_clock_run_n_oe_o = ~st_reg.sdis | st_reg.cstop;
   assign card_clock_run_n_o    = st_reg.cstop;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_next = st_reg;
      st_next.sync1 = {power_good_i, card_clock_run_n_i, card_status_change_pin_i,
                       card_voltage_sense_i, card_detect_second_n_i,
                       card_detect_first_n_i};
      st_next.sync2 = st_reg.sync1;
      st_next.cd_prev      = {cd2_s, cd1_s};
      st_next.sts_prev     = sts_s;
      st_next.pwr_prev     = present_word[`CSC_B_PWRCYC];
      st_next.present_prev = present_s;
      st_next.ack   = (avs_read_i | avs_write_i) & ~st_reg.ack;
      retest = wr_acc & (avs_address_i == `CSC_OFF_FORCE) & wdat[`CSC_B_VSTEST];
      sample = (present_s & ~st_reg.present_prev) | retest;

      // software side first, hardware sets after so that a set wins
      if (wr_acc) begin
         case (avs_address_i)
            `CSC_OFF_EVENT: st_next.evt = st_reg.evt & ~wdat[3:0];
            `CSC_OFF_MASK:  st_next.msk = wdat[3:0];
            `CSC_OFF_FORCE: begin
               if (wmask[`CSC_B_CARD3V]) begin
                  st_next.card3v = wdat[`CSC_B_CARD3V];
                  st_next.card5v = wdat[`CSC_B_CARD5V];
                  st_next.vs_ok  = 1'b0;
               end
               if (wmask[`CSC_B_ILLVCC]) begin
                  st_next.illvcc = wdat[`CSC_B_ILLVCC];
               end
               if (wmask[`CSC_B_LOST]) begin
                  st_next.lost   = wdat[`CSC_B_LOST];
               end
               if (wmask[`CSC_B_UNREC] && !present_s) begin
                  st_next.unrec = wdat[`CSC_B_UNREC];
                  st_next.cb    = wdat[`CSC_B_CB];
                  st_next.b16   = wdat[`CSC_B_B16];
               end
            end
            `CSC_OFF_POWER: begin
               st_next.vcc = wdat[`CSC_VCC_LSB +: 3];
               st_next.vpp = wdat[2:0];
            end
            `CSC_OFF_CLOCK: begin
               st_next.sdis  = wdat[`CSC_B_SDIS];
               st_next.cstop = wdat[`CSC_B_CSTOP];
            end
            default: ;
         endcase
      end
      if (rd_acc && !st_reg.ack) begin
         case (avs_address_i)
            `CSC_OFF_EVENT:   st_next.rdata = {28'h0, st_reg.evt};
            `CSC_OFF_MASK:    st_next.rdata = {28'h0, st_reg.msk};
            `CSC_OFF_PRESENT,
            `CSC_OFF_FORCE:   st_next.rdata = present_word;
            `CSC_OFF_POWER:   st_next.rdata = {25'h0, st_reg.vcc, 1'b0, st_reg.vpp};
            `CSC_OFF_CLOCK:   st_next.rdata = {30'h0, st_reg.sdis, st_reg.cstop};
            default:          st_next.rdata = `CSC_RESET_WORD;
         endcase
      end

      // illegal code is judged against the sensed capability
      if (wr_acc && avs_address_i == `CSC_OFF_POWER && wmask[`CSC_VCC_LSB]) begin
         case (wdat[`CSC_VCC_LSB +: 3])
            `CSC_CODE_OFF: ;
            `CSC_CODE_5V:  st_next.illvcc = st_next.illvcc | ~st_reg.card5v | st_reg.cb;
            `CSC_CODE_3V:  st_next.illvcc = st_next.illvcc | ~st_reg.card3v;
            default:       st_next.illvcc = 1'b1;
         endcase
      end

      // sense pins decode: 00 16-bit 5V, 01 16-bit dual, 10 32-bit 3V, 11 unknown
      if (sample) begin
         st_next.vs_ok  = 1'b1;
         st_next.card3v = vs_s[0] ^ vs_s[1];
         st_next.card5v = ~vs_s[1];
         if (vs_s == 2'b11) begin
            st_next.unrec  = 1'b1;
            st_next.card3v = 1'b0;
            st_next.card5v = 1'b0;
         end else begin
            st_next.unrec = 1'b0;
            st_next.cb    = vs_s[1];
            st_next.b16   = ~vs_s[1];
         end
      end

      if (!present_s && st_reg.present_prev) begin
         st_next.msk[`CSC_B_STSCHG] = 1'b0;
         st_next.vs_ok = 1'b0;
         if (xfer_pending_i) begin
            st_next.lost = 1'b1;
         end
      end

      // event flags: hardware and forced sets win over the clear above
      if (cd1_s != st_reg.cd_prev[0]) st_next.evt[`CSC_B_CD1] = 1'b1;
      if (cd2_s != st_reg.cd_prev[1]) st_next.evt[`CSC_B_CD2] = 1'b1;
      if (sts_s && !st_reg.sts_prev)  st_next.evt[`CSC_B_STSCHG] = 1'b1;
      if (present_word[`CSC_B_PWRCYC] && !st_reg.pwr_prev) begin
         st_next.evt[`CSC_B_PWRCYC] = 1'b1;
      end
      if (wr_acc && avs_address_i == `CSC_OFF_FORCE) begin
         st_next.evt = st_next.evt | wdat[3:0];
      end

      // ****************************************************************
      // card clock
      // ****************************************************************
      case (st_reg.clk_st)
         CSC_CLK_RUN: begin
            if (st_reg.cstop) begin
               st_next.clk_st   = CSC_CLK_STOPPING;
               st_next.stop_cnt = 3'h0;
            end else if (st_reg.sdis && clkrun_n_s && !st_reg.card_bus_clock) begin
               st_next.clk_st = CSC_CLK_STOPPED;
            end
         end
         CSC_CLK_STOPPING: begin
            if (st_reg.card_bus_clock && st_reg.div == HALF_M1) begin
               st_next.stop_cnt = st_reg.stop_cnt + 3'h1;
               if (st_reg.stop_cnt + 3'h1 == `CSC_STOP_CLOCKS) begin
                  st_next.clk_st = CSC_CLK_STOPPED;
               end
            end
         end
         CSC_CLK_STOPPED: begin
            if (!st_reg.cstop && (!st_reg.sdis || !clkrun_n_s)) begin
               st_next.clk_st = CSC_CLK_RUN;
            end
         end
         default: st_next.clk_st = CSC_CLK_RUN;
      endcase
      // the clock parks low; a start-disable stop taken as the divider wraps still lets one clk_i-cycle pulse out
      if (st_reg.clk_st == CSC_CLK_STOPPED) begin
         st_next.div  = 8'h00;
         st_next.card_bus_clock = 1'b0;
      end else if (st_reg.div == HALF_M1) begin
         st_next.div  = 8'h00;
         st_next.card_bus_clock = ~st_reg.card_bus_clock;
      end else begin
         st_next.div = st_reg.div + 8'h01;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   logic [3:0] stop_edges;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stop_edges <= 4'h0;
      end else if (st_reg.clk_st != CSC_CLK_STOPPING) begin
         stop_edges <= 4'h0;
      end else if (st_reg.card_bus_clock && st_reg.div == HALF_M1) begin
         stop_edges <= stop_edges + 4'h1;
      end
   end

   default clocking cb_chk @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   a_pwr_irq_mask: assert property (
      (st_reg.evt == 4'b1000 && !st_reg.msk[3]) |-> !status_change_irq_o)
      else $error("power cycle event raised irq while masked");
   a_cd_irq_mask: assert property (
      (st_reg.evt[3] == 1'b0 && st_reg.evt[0] == 1'b0 && st_reg.msk[2:1] == 2'b00)
      |-> !status_change_irq_o)
      else $error("detect event raised irq while masked");
   a_cd_edge_event: assert property (
      (cd1_s != st_reg.cd_prev[0]) |=> st_reg.evt[`CSC_B_CD1])
      else $error("detect change did not set its event");
   a_sts_en_clear: assert property (
      (!present_s && st_reg.present_prev) |=> !st_reg.msk[0])
      else $error("status enable survived card removal");
   a_no_cb_5v: assert property (
      st_reg.cb |-> vcc_request_o != `CSC_CODE_5V)
      else $error("5V applied to 32-bit card");
   a_vs_block: assert property (
      (wr_acc && avs_address_i == `CSC_OFF_FORCE && wmask[`CSC_B_CARD3V]
       && !wdat[`CSC_B_VSTEST] && !(present_s && !st_reg.present_prev))
      |=> vcc_request_o == `CSC_CODE_OFF)
      else $error("vcc applied after forced voltage flag");
   a_force_type_ign: assert property (
      (wr_acc && avs_address_i == `CSC_OFF_FORCE && present_s
       && st_reg.present_prev && !wdat[`CSC_B_VSTEST]) |=> $stable(st_reg.unrec))
      else $error("forced type written with card inserted");
   a_force_evt_set: assert property (
      (wr_acc && avs_address_i == `CSC_OFF_FORCE && wdat[`CSC_B_PWRCYC])
      |=> st_reg.evt[`CSC_B_PWRCYC])
      else $error("forced power event not set");
   a_lost_set: assert property (
      (!present_s && st_reg.present_prev && xfer_pending_i) |=> st_reg.lost)
      else $error("data lost flag missed");
   a_stop_count: assert property (
      (st_reg.clk_st == CSC_CLK_STOPPING) |-> stop_edges < 4'h5)
      else $error("card clock ran past four cycles after stop");
   a_stop_runline: assert property (
      st_reg.cstop |-> (card_clock_run_n_oe_o && card_clock_run_n_o))
      else $error("run line not driven high during stop");
   a_run_asserted: assert property (
      (!st_reg.sdis && !st_reg.cstop) |-> (card_clock_run_n_oe_o && !card_clock_run_n_o))
      else $error("clock run not asserted while start enabled");
   a_wait_one: assert property (
      ($rose(avs_read_i) && !avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("read not answered after one wait state");

   c_insert_16: cover property ($rose(st_reg.b16));
   c_insert_cb: cover property ($rose(st_reg.cb));
   c_clock_stop: cover property (st_reg.clk_st == CSC_CLK_STOPPED && st_reg.cstop);
   c_irq: cover property ($rose(status_change_irq_o));
   c_card_removed: cover property (!present_s && st_reg.present_prev);

endmodule // csc_socket_bank

`default_nettype wire

// ===== csc_card_model.sv
// card in the socket plus the external power switch, on their own 80 ns clock
// assumes the bench steers insertion, sense code, status pin and clock-run requests
`timescale 1ns/100ps
`default_nettype none

module csc_card_model (
   input  wire logic       present_i,
   input  wire logic [1:0] sense_i,
   input  wire logic       sts_i,
   input  wire logic       run_req_i,
   input  wire logic [2:0] vcc_i,
   input  wire logic       run_n_i,
   input  wire logic       run_n_oe_i,
   output var  logic       cd1_n_o,
   output var  logic       cd2_n_o,
   output var  logic [1:0] vs_o,
   output var  logic       sts_o,
   output var  logic       run_line_o,
   output var  logic       pgood_o
);
   logic       lclk;
   logic [1:0] up_cnt;

   // phase offset keeps pin changes unrelated to the bus clock
   initial begin
      lclk = 1'b0;
      up_cnt = 2'h0;
      cd1_n_o = 1'b1;
      cd2_n_o = 1'b1;
      vs_o = 2'h3;
      sts_o = 1'b0;
      pgood_o = 1'b0;
      #13;
      forever #40 lclk = ~lclk;
   end

   // pull-ups: detect and sense float high without a card
   always @(posedge lclk) begin
      cd1_n_o <= ~present_i;
      cd2_n_o <= ~present_i;
      vs_o <= present_i ? sense_i : 2'h3;
      sts_o <= present_i & sts_i;
   end

   // switch only powers up on the 5v and 3.3v codes, slowly
   always @(posedge lclk) begin
      if (vcc_i == 3'h2 || vcc_i == 3'h3) begin
         up_cnt <= (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
      end else begin
         up_cnt <= 2'h0;
      end
      pgood_o <= (up_cnt == 2'h3);
   end

   // open line with pull-up: low when either party pulls it
   assign run_line_o = ~((run_n_oe_i & ~run_n_i) | (run_req_i & present_i));
endmodule // csc_card_model

`default_nettype wire

// ===== tb.sv
// self-checking bench of the socket status and control bank
// assumes csc_card_model on the socket side and an avalon-mm master here
`include "csc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module tb;
   logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, xfer = 1'b0;
   logic        cin = 1'b0, sts = 1'b0, rreq = 1'b0;
   logic [1:0]  sns = 2'h0;
   logic [3:0]  be = 4'hf;
   logic [5:0]  adr = 6'h0;
   logic [31:0] wd = 32'h0, q;
   int          n_fail = 0, checks_done = 0, e;
   wire logic        cd1, cd2, stsp, runl, pg, wreq, rno, roe, card_bus_clock, mcb, m16, irq;
   wire logic [1:0]  vs;
   wire logic [2:0]  vcc, vpp;
   wire logic [31:0] rdat;
   localparam logic [5:0]  RA [8] = '{`CSC_OFF_MASK, `CSC_OFF_MASK, `CSC_OFF_POWER,
      `CSC_OFF_POWER, `CSC_OFF_CLOCK, `CSC_OFF_CLOCK, 6'h14, 6'h3c};
   localparam logic [31:0] RD [8] = '{32'hffff_ffff, 0, 32'hffff_ffb3, 0, 32'hffff_ffff, 0,
      32'hffff_ffff, 32'hffff_ffff};
   localparam logic [31:0] RX [8] = '{32'hf, 0, 32'h33, 0, 32'h3, 0, 0, 0};

   initial begin
      forever #2.5 clk = ~clk;
   end

   csc_socket_bank dut (.clk_i(clk), .resetn_i(rstn), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .card_detect_first_n_i(cd1),
      .card_detect_second_n_i(cd2), .card_voltage_sense_i(vs),
      .card_status_change_pin_i(stsp), .card_clock_run_n_i(runl),
      .card_clock_run_n_o(rno), .card_clock_run_n_oe_o(roe), .card_bus_clock_o(card_bus_clock),
      .power_good_i(pg), .xfer_pending_i(xfer), .vcc_request_o(vcc),
      .vpp_request_o(vpp), .mode_cardbus_o(mcb), .mode_16bit_o(m16),
      .status_change_irq_o(irq));

   csc_card_model card (.present_i(cin), .sense_i(sns), .sts_i(sts), .run_req_i(rreq),
      .vcc_i(vcc), .run_n_i(rno), .run_n_oe_i(roe), .cd1_n_o(cd1), .cd2_n_o(cd2),
      .vs_o(vs), .sts_o(stsp), .run_line_o(runl), .pgood_o(pg));

   // ***********************
   // shared tasks
   // ***********************
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // request held until a rising edge sees waitrequest low; read data taken at that edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] b = 4'hf);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      be <= b;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      if (wreq !== 1'b0) begin
         n_fail++;
         end_sim();
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] m,
                     input logic [31:0] x);
      bus(1'b0, a, 32'h0);
      chk(nm, q & m, x);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic edges();
      logic p;
      e = 0;
      p = card_bus_clock;
      repeat (64) begin
         @(negedge clk);
         if (card_bus_clock !== p) e++;
         p = card_bus_clock;
      end
      @(posedge clk);
   endtask

   initial begin
      #200000;
      n_fail++;
      end_sim();
   end

   // ***********************
   // main sequence
   // ***********************
   initial begin
      repeat (20) @(posedge clk);
      chk("readdata in reset", rdat, 32'h0);
      chk("irq in reset", {31'h0, irq}, 32'h0);
      rstn <= 1'b1;
      wt(40);
      foreach (RA[i]) rc("reset word", RA[i], 32'hffff_ffff, 32'h0);
      foreach (RA[i]) begin
         bus(1'b1, RA[i], RD[i]);
         rc("row readback", RA[i], 32'hffff_ffff, RX[i]);
      end
      $display("test register rows done");
      rc("present empty", `CSC_OFF_PRESENT, 32'hffff_ffff, 32'h3000_0206);
      bus(1'b1, `CSC_OFF_FORCE, 32'h0, 4'h2);
      bus(1'b1, `CSC_OFF_EVENT, 32'hf);
      sns <= 2'h2;
      cin <= 1'b1;
      wt(40);
      rc("present cardbus", `CSC_OFF_PRESENT, 32'hffff_ffff, 32'h3000_0820);
      chk("mode cardbus", {31'h0, mcb}, 32'h1);
      rc("detect events", `CSC_OFF_EVENT, 32'hf, 32'h6);
      chk("irq detect masked", {31'h0, irq}, 32'h0);
      bus(1'b1, `CSC_OFF_MASK, 32'h6);
      chk("irq detect open", {31'h0, irq}, 32'h1);
      bus(1'b1, `CSC_OFF_EVENT, 32'hf);
      bus(1'b1, `CSC_OFF_MASK, 32'h0);
      bus(1'b1, `CSC_OFF_POWER, 32'h20);
      chk("vcc 5v on cardbus", {29'h0, vcc}, 32'h0);
      rc("illegal vcc", `CSC_OFF_PRESENT, 32'h200, 32'h200);
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, `CSC_OFF_POWER, 32'h30 | k);
         chk("vcc 3v", {29'h0, vcc}, 32'h3);
         chk("vpp code", {29'h0, vpp}, k);
      end
      wt(80);
      rc("power up", `CSC_OFF_PRESENT, 32'h8, 32'h8);
      rc("power event", `CSC_OFF_EVENT, 32'h8, 32'h8);
      chk("irq power masked", {31'h0, irq}, 32'h0);
      bus(1'b1, `CSC_OFF_MASK, 32'h8);
      chk("irq power open", {31'h0, irq}, 32'h1);
      bus(1'b1, `CSC_OFF_EVENT, 32'hf);
      bus(1'b1, `CSC_OFF_MASK, 32'h0);
      $display("test insertion and power done");
      bus(1'b1, `CSC_OFF_FORCE, 32'hc00, 4'h2);
      rc("forced voltage", `CSC_OFF_PRESENT, 32'hf00, 32'hc00);
      chk("vcc held off", {29'h0, vcc}, 32'h0);
      bus(1'b1, `CSC_OFF_FORCE, 32'h4000, 4'h2);
      wt(8);
      rc("retest", `CSC_OFF_PRESENT, 32'hf00, 32'h800);
      chk("vcc after retest", {29'h0, vcc}, 32'h3);
      wt(80);
      bus(1'b1, `CSC_OFF_EVENT, 32'hf);
      bus(1'b1, `CSC_OFF_FORCE, 32'h1f, 4'h1);
      rc("forced events", `CSC_OFF_EVENT, 32'hf, 32'hf);
      rc("present kept", `CSC_OFF_PRESENT, 32'hb8, 32'h28);
      bus(1'b1, `CSC_OFF_EVENT, 32'hf);
      bus(1'b1, `CSC_OFF_FORCE, 32'h0, 4'h1);
      rc("force zero", `CSC_OFF_EVENT, 32'hf, 32'h0);
      bus(1'b1, `CSC_OFF_MASK, 32'h1);
      sts <= 1'b1;
      wt(40);
      rc("status event", `CSC_OFF_EVENT, 32'h1, 32'h1);
      chk("irq status", {31'h0, irq}, 32'h1);
      rc("status pin", `CSC_OFF_PRESENT, 32'h1, 32'h1);
      sts <= 1'b0;
      wt(40);
      bus(1'b1, `CSC_OFF_EVENT, 32'hf);
      xfer <= 1'b1;
      cin <= 1'b0;
      wt(40);
      xfer <= 1'b0;
      rc("enable cleared", `CSC_OFF_MASK, 32'hf, 32'h0);
      rc("removal", `CSC_OFF_PRESENT, 32'h1a6, 32'h126);
      bus(1'b1, `CSC_OFF_FORCE, 32'h300, 4'h2);
      rc("forced lost", `CSC_OFF_PRESENT, 32'h300, 32'h300);
      bus(1'b1, `CSC_OFF_FORCE, 32'h10, 4'h1);
      rc("forced type", `CSC_OFF_PRESENT, 32'hb0, 32'h10);
      chk("mode 16bit", {31'h0, m16}, 32'h1);
      sns <= 2'h3;
      cin <= 1'b1;
      wt(40);
      rc("unrecognized", `CSC_OFF_PRESENT, 32'h80, 32'h80);
      cin <= 1'b0;
      wt(40);
      rc("unrecognized held", `CSC_OFF_PRESENT, 32'h80, 32'h80);
      sns <= 2'h0;
      cin <= 1'b1;
      wt(40);
      rc("16bit card", `CSC_OFF_PRESENT, 32'hcb0, 32'h410);
      $display("test force and removal done");
      bus(1'b1, `CSC_OFF_CLOCK, 32'h1);
      wt(40);
      edges();
      chk("stopped clock", e, 0);
      chk("run line high", {30'h0, roe, rno}, 32'h3);
      bus(1'b1, `CSC_OFF_CLOCK, 32'h0);
      edges();
      chk("running clock", e > 0, 1);
      chk("run asserted", {30'h0, roe, rno}, 32'h2);
      bus(1'b1, `CSC_OFF_CLOCK, 32'h2);
      wt(40);
      edges();
      chk("idle card clock", e, 0);
      chk("run released", {31'h0, roe}, 32'h0);
      rreq <= 1'b1;
      wt(40);
      edges();
      chk("card restarts", e > 0, 1);
      $display("test card clock done");
      end_sim();
   end
endmodule // tb

`default_nettype wire
